// [rtl/nco_top.sv]
// APB register file, clock source selection and interrupt of the oscillator
`include "nco_defines.svh"

module nco_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Oscillator clock sources
    input  wire logic        ext_clock_pin,
    input  wire logic        internal_hf_osc,
    input  wire logic        logic_cell_output,
    // Oscillator output
    output logic             nco_out,
    output logic             nco_pin_o,
    output logic             nco_pin_oe,
    // Interrupt
    output logic             irq
);

    function automatic logic [3:0] nco_decode(input logic [7:0] addr);
        logic [3:0] idx;
        unique case (addr)
            `NCO_OFF_CTRL:     idx = `NCO_IDX_CTRL;
            `NCO_OFF_CLKCTRL:  idx = `NCO_IDX_CLKCTRL;
            `NCO_OFF_ACCL:     idx = `NCO_IDX_ACCL;
            `NCO_OFF_ACCH:     idx = `NCO_IDX_ACCH;
            `NCO_OFF_ACCU:     idx = `NCO_IDX_ACCU;
            `NCO_OFF_INCL:     idx = `NCO_IDX_INCL;
            `NCO_OFF_INCH:     idx = `NCO_IDX_INCH;
            `NCO_OFF_IRQ_STAT: idx = `NCO_IDX_IRQ_STAT;
            `NCO_OFF_IRQ_MASK: idx = `NCO_IDX_IRQ_MASK;
            default:           idx = `NCO_IDX_NONE;
        endcase
        return idx;
    endfunction : nco_decode

    nco_pkg::nco_regs_state_type s_q;
    nco_pkg::nco_regs_state_type s_d;

    logic [`NCO_NUM_SRC-1:0] src_raw;
    logic [`NCO_ACC_W-1:0]   acc;
    logic                    ovf;
    logic                    out_state;
    logic [3:0]              wr_idx;
    logic [3:0]              rd_idx;
    logic                    wr_en;
    logic                    inc_lo_wr;
    logic [2:0]              acc_wr;
    logic [7:0]              wbyte;

    assign src_raw = {logic_cell_output, internal_hf_osc, ext_clock_pin};
    assign wbyte   = pwdata[7:0];
    assign wr_idx  = nco_decode(paddr);
    assign rd_idx  = nco_decode(paddr);
    // Zero wait state: read data is captured in the setup cycle
    assign pready  = psel & penable;
    assign pslverr = psel & penable & (wr_idx == `NCO_IDX_NONE);
    assign wr_en   = psel & penable & pwrite & (wr_idx != `NCO_IDX_NONE);

    assign inc_lo_wr = wr_en & (wr_idx == `NCO_IDX_INCL);
    assign acc_wr    = {wr_en & (wr_idx == `NCO_IDX_ACCU),
                        wr_en & (wr_idx == `NCO_IDX_ACCH),
                        wr_en & (wr_idx == `NCO_IDX_ACCL)};

    always_comb begin
        logic [`NCO_NUM_SRC-1:0] rise;
        rise = '0;
        s_d  = s_q;
        // Three-stage synchroniser; a level counts once stages two and three agree
        for (int i = 0; i < `NCO_NUM_SRC; i++) begin
            s_d.sync[i] = {s_q.sync[i][1:0], src_raw[i]};
            if (s_q.sync[i][1] == s_q.sync[i][2]) begin
                s_d.stable[i] = s_q.sync[i][2];
            end
            rise[i] = s_d.stable[i] & ~s_q.stable[i];
        end
        unique case (s_q.cks)
            `NCO_CKS_PIN:   s_d.tick = rise[0];
            `NCO_CKS_SYS:   s_d.tick = 1'b1;
            `NCO_CKS_HFOSC: s_d.tick = rise[1];
            `NCO_CKS_LCELL: s_d.tick = rise[2];
        endcase

        // Register writes
        if (wr_en) begin
            unique case (wr_idx)
                `NCO_IDX_CTRL: begin
                    s_d.en  = wbyte[`NCO_CTRL_EN];
                    s_d.oe  = wbyte[`NCO_CTRL_OE];
                    s_d.pol = wbyte[`NCO_CTRL_POL];
                    s_d.pfm = wbyte[`NCO_CTRL_PFM];
                end
                `NCO_IDX_CLKCTRL: begin
                    s_d.pws = wbyte[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
                    s_d.cks = wbyte[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];
                end
                `NCO_IDX_INCL:     s_d.inc_reg[7:0]  = wbyte;
                `NCO_IDX_INCH:     s_d.inc_reg[15:8] = wbyte;
                `NCO_IDX_IRQ_MASK: s_d.irq_mask      = wbyte[0];
                default: begin
                end
            endcase
        end
        // Write one clears, a same-cycle overflow wins
        if (wr_en && wr_idx == `NCO_IDX_IRQ_STAT && wbyte[0]) begin
            s_d.irq_stat = 1'b0;
        end
        if (ovf) begin
            s_d.irq_stat = 1'b1;
        end

        // Read data captured in the setup cycle
        if (psel && !penable) begin
            s_d.rdata = '0;
            unique case (rd_idx)
                `NCO_IDX_CTRL: begin
                    s_d.rdata[`NCO_CTRL_EN]  = s_q.en;
                    s_d.rdata[`NCO_CTRL_OE]  = s_q.oe;
                    s_d.rdata[`NCO_CTRL_OUT] = out_state;
                    s_d.rdata[`NCO_CTRL_POL] = s_q.pol;
                    s_d.rdata[`NCO_CTRL_PFM] = s_q.pfm;
                end
                `NCO_IDX_CLKCTRL: begin
                    s_d.rdata[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO] = s_q.pws;
                    s_d.rdata[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO] = s_q.cks;
                end
                `NCO_IDX_ACCL:     s_d.rdata[7:0] = acc[7:0];
                `NCO_IDX_ACCH:     s_d.rdata[7:0] = acc[15:8];
                `NCO_IDX_ACCU:     s_d.rdata[3:0] = acc[19:16];
                `NCO_IDX_INCL:     s_d.rdata[7:0] = s_q.inc_reg[7:0];
                `NCO_IDX_INCH:     s_d.rdata[7:0] = s_q.inc_reg[15:8];
                `NCO_IDX_IRQ_STAT: s_d.rdata[0]   = s_q.irq_stat;
                `NCO_IDX_IRQ_MASK: s_d.rdata[0]   = s_q.irq_mask;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.inc_reg <= `NCO_INC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    nco_core i_nco_core (
        .mclk      (mclk),
        .resetn    (resetn),
        .tick      (s_q.tick),
        .enable    (s_q.en),
        .pfm       (s_q.pfm),
        .pws       (s_q.pws),
        .inc_reg   (s_q.inc_reg),
        .inc_lo_wr (inc_lo_wr),
        .acc_wr    (acc_wr),
        .wdata     (wbyte),
        .acc       (acc),
        .ovf       (ovf),
        .out_state (out_state)
    );

    assign prdata     = s_q.rdata;
    assign nco_out    = out_state ^ s_q.pol;
    assign nco_pin_o  = out_state ^ s_q.pol;
    assign nco_pin_oe = s_q.oe & s_q.en;
    assign irq        = s_q.irq_stat & s_q.irq_mask;

endmodule : nco_top

// [rtl/nco_defines.svh]
// Offsets, field positions and reset values of the oscillator block
`ifndef NCO_DEFINES_SVH
`define NCO_DEFINES_SVH

`define NCO_ADDR_W        8
`define NCO_OFF_CTRL      8'h00
`define NCO_OFF_CLKCTRL   8'h04
`define NCO_OFF_ACCL      8'h08
`define NCO_OFF_ACCH      8'h0c
`define NCO_OFF_ACCU      8'h10
`define NCO_OFF_INCL      8'h14
`define NCO_OFF_INCH      8'h18
`define NCO_OFF_IRQ_STAT  8'h1c
`define NCO_OFF_IRQ_MASK  8'h20

`define NCO_IDX_CTRL      4'h0
`define NCO_IDX_CLKCTRL   4'h1
`define NCO_IDX_ACCL      4'h2
`define NCO_IDX_ACCH      4'h3
`define NCO_IDX_ACCU      4'h4
`define NCO_IDX_INCL      4'h5
`define NCO_IDX_INCH      4'h6
`define NCO_IDX_IRQ_STAT  4'h7
`define NCO_IDX_IRQ_MASK  4'h8
`define NCO_IDX_NONE      4'hf

`define NCO_CTRL_EN       7
`define NCO_CTRL_OE       6
`define NCO_CTRL_OUT      5
`define NCO_CTRL_POL      4
`define NCO_CTRL_PFM      0
`define NCO_CLK_PWS_HI    7
`define NCO_CLK_PWS_LO    5
`define NCO_CLK_CKS_HI    1
`define NCO_CLK_CKS_LO    0

`define NCO_CKS_PIN       2'h0
`define NCO_CKS_SYS       2'h1
`define NCO_CKS_HFOSC     2'h2
`define NCO_CKS_LCELL     2'h3

`define NCO_ACC_W         20
`define NCO_INC_W         16
`define NCO_INC_RESET     16'h0001
`define NCO_NUM_SRC       3
`define NCO_SYNC_LEN      3

`endif

// [rtl/nco_pkg.sv]
// State types of the oscillator block
`include "nco_defines.svh"

package nco_pkg;

    typedef struct packed {
        logic [`NCO_ACC_W-1:0] acc;
        logic [`NCO_INC_W-1:0] inc_act;
        logic                  inc_pend;
        logic                  ovf_pend;
        logic [7:0]            width_cnt;
        logic                  out_state;
        logic                  ovf;
    } nco_core_state_type;

    typedef struct packed {
        logic [`NCO_NUM_SRC-1:0][`NCO_SYNC_LEN-1:0] sync;
        logic [`NCO_NUM_SRC-1:0]                    stable;
        logic                                       tick;
        logic                                       en;
        logic                                       oe;
        logic                                       pol;
        logic                                       pfm;
        logic [2:0]                                 pws;
        logic [1:0]                                 cks;
        logic [`NCO_INC_W-1:0]                      inc_reg;
        logic                                       irq_stat;
        logic                                       irq_mask;
        logic [31:0]                                rdata;
    } nco_regs_state_type;

endpackage : nco_pkg

// [rtl/nco_core.sv]
// Accumulator, increment buffer and output shaping of the oscillator
`include "nco_defines.svh"

module nco_core (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Oscillator clock edge, one cycle per selected source rising edge
    input  wire logic                  tick,
    // Configuration
    input  wire logic                  enable,
    input  wire logic                  pfm,
    input  wire logic [2:0]            pws,
    input  wire logic [`NCO_INC_W-1:0] inc_reg,
    // Software writes
    input  wire logic                  inc_lo_wr,
    input  wire logic [2:0]            acc_wr,
    input  wire logic [7:0]            wdata,
    // State
    output logic      [`NCO_ACC_W-1:0] acc,
    output logic                       ovf,
    output logic                       out_state
);

    nco_pkg::nco_core_state_type s_q;
    nco_pkg::nco_core_state_type s_d;

    logic [`NCO_ACC_W:0] sum;
    logic [7:0]          width;

    always_comb begin
        s_d   = s_q;
        sum   = {1'b0, s_q.acc} + {{(`NCO_ACC_W + 1 - `NCO_INC_W){1'b0}}, s_q.inc_act};
        width = 8'h01 << pws;
        s_d.ovf = 1'b0;
        // Double buffer: a running oscillator picks up a new step only at its own edge
        s_d.inc_pend = (s_q.inc_pend & ~tick) | inc_lo_wr;
        if (!enable) begin
            s_d.inc_act   = inc_reg;
            s_d.inc_pend  = 1'b0;
            s_d.ovf_pend  = 1'b0;
            s_d.out_state = 1'b0;
        end else if (tick) begin
            s_d.acc = sum[`NCO_ACC_W-1:0];
            s_d.ovf = sum[`NCO_ACC_W];
            if (s_q.inc_pend) begin
                s_d.inc_act = inc_reg;
            end
            if (!pfm) begin
                s_d.ovf_pend = 1'b0;
                if (sum[`NCO_ACC_W]) begin
                    s_d.out_state = ~s_q.out_state;
                end
            end else begin
                s_d.ovf_pend = sum[`NCO_ACC_W];
                if (s_q.ovf_pend) begin
                    s_d.out_state = 1'b1;
                    s_d.width_cnt = width;
                end else if (s_q.out_state) begin
                    if (s_q.width_cnt <= 8'h01) begin
                        s_d.out_state = 1'b0;
                    end else begin
                        s_d.width_cnt = s_q.width_cnt - 8'h01;
                    end
                end
            end
        end
        // Software write wins over the running sum in the same cycle
        if (acc_wr[0]) begin
            s_d.acc[7:0] = wdata;
        end
        if (acc_wr[1]) begin
            s_d.acc[15:8] = wdata;
        end
        if (acc_wr[2]) begin
            s_d.acc[19:16] = wdata[3:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.inc_act <= `NCO_INC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign acc       = s_q.acc;
    assign ovf       = s_q.ovf;
    assign out_state = s_q.out_state;

endmodule : nco_core

// [testbench/nco_top_sva.sv]
// Port-level assertions of the oscillator register block
module nco_top_sva (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Outputs
    input wire logic        nco_out,
    input wire logic        nco_pin_o,
    input wire logic        nco_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready missing in access");
    property p_unmapped; psel && penable && paddr > 8'h20 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
    property p_mapped; psel && penable && paddr == 8'h14 |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("error on mapped access");
    property p_upper; psel && penable |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data above byte not zero");
    property p_accu; psel && penable && !pwrite && paddr == 8'h10 |-> prdata[7:4] == 4'h0;
    endproperty
    a_accu: assert property (p_accu) else $error("upper accumulator nibble not zero");
    property p_clk; psel && penable && !pwrite && paddr == 8'h04 |-> prdata[4:2] == 3'h0;
    endproperty
    a_clk: assert property (p_clk) else $error("clock control bits 4:2 not zero");
    property p_pin; nco_pin_o == nco_out; endproperty
    a_pin: assert property (p_pin) else $error("pin level differs from output");
    property p_rst; $rose(resetn) |-> !irq && !nco_pin_oe && !nco_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_sticky; $fell(irq) |-> $past(psel && penable && pwrite) || !$past(resetn);
    endproperty
    a_sticky: assert property (p_sticky) else $error("irq dropped without a write");
endmodule : nco_top_sva

bind nco_top nco_top_sva i_nco_top_sva (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nco_out(nco_out), .nco_pin_o(nco_pin_o), .nco_pin_oe(nco_pin_oe),
    .irq(irq));

// [testbench/tb_nco_top.sv]
// Self-checking bench of the oscillator register block
module tb_nco_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic        nco_out, nco_pin_o, nco_pin_oe, irq;
    logic [7:0]  paddr, rd;
    logic [31:0] pwdata, prdata;
    logic [2:0]  src;
    logic [19:0] e;
    int          n_mismatch, checks, w;

    nco_top i_nco_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ext_clock_pin(src[0]), .internal_hf_osc(src[1]),
        .logic_cell_output(src[2]), .nco_out(nco_out), .nco_pin_o(nco_pin_o),
        .nco_pin_oe(nco_pin_oe), .irq(irq));

    always #5 mclk = ~mclk;

    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic bail();
        n_mismatch++;
        final_report();
    endtask : bail

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    // One transfer; an idle cycle precedes it so no signal is driven twice per step
    // Trailing edge lets register-driven outputs settle before the caller checks them
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bail();
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    // Source pins get 1, 2 and 3 rising edges
    task automatic pulse();
        for (int k = 0; k < 3; k++) begin
            repeat (6) @(posedge mclk);
            src <= {k < 3, k < 2, k < 1};
            repeat (6) @(posedge mclk);
            src <= 3'h0;
        end
        repeat (10) @(posedge mclk);
    endtask : pulse

    task automatic measure(output int wid);
        int n;
        n = 0;
        wid = 0;
        while (nco_out !== 1'b0 && n < 1000) begin @(posedge mclk); n++; end
        while (nco_out !== 1'b1 && n < 1000) begin @(posedge mclk); n++; end
        while (nco_out === 1'b1 && n < 1000) begin @(posedge mclk); n++; wid++; end
        if (n >= 1000) bail();
    endtask : measure

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 3'h0;
        n_mismatch = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 8'h00);
            check8("reset value", (i == 5) ? 8'h01 : 8'h00, rd);
        end
        for (int i = 1; i < 7; i++) begin
            apb(1'b1, 8'(i * 4), 8'hff);
            apb(1'b0, 8'(i * 4), 8'h00);
            check8("readback", (i == 1) ? 8'he3 : (i == 4) ? 8'h0f : 8'hff, rd);
        end
        apb(1'b0, 8'h40, 8'h00);
        check8("unmapped data", 8'h00, rd);
        check8("unmapped error", 8'h01, {7'h0, err});
        // Inverted polarity shows the idle level as high
        apb(1'b1, 8'h00, 8'h10);
        check8("inverted idle output", 8'h01, {7'h0, nco_out});
        apb(1'b0, 8'h00, 8'h00);
        check8("control readback", 8'h10, rd);
        apb(1'b1, 8'h18, 8'h80);
        apb(1'b1, 8'h14, 8'h01);
        for (int cs = 0; cs < 4; cs++) begin
            if (cs == 1) continue;
            apb(1'b1, 8'h00, 8'h00);
            apb(1'b1, 8'h04, 8'(cs));
            for (int b = 0; b < 3; b++) apb(1'b1, 8'h08 + 8'(b * 4), 8'h00);
            apb(1'b1, 8'h00, 8'h80);
            pulse();
            apb(1'b1, 8'h00, 8'h00);
            e = 20'((cs == 0 ? 1 : cs) * 20'h08001);
            for (int b = 0; b < 3; b++) begin
                apb(1'b0, 8'h08 + 8'(b * 4), 8'h00);
                check8("accumulator", 8'(e >> (b * 8)), rd);
            end
        end
        apb(1'b1, 8'h04, 8'h00);
        for (int b = 0; b < 3; b++) apb(1'b1, 8'h08 + 8'(b * 4), 8'hff);
        apb(1'b1, 8'h20, 8'h01);
        apb(1'b1, 8'h00, 8'hc0);
        pulse();
        check8("toggled output", 8'h01, {7'h0, nco_out});
        check8("pin enable", 8'h01, {7'h0, nco_pin_oe});
        check8("irq raised", 8'h01, {7'h0, irq});
        apb(1'b0, 8'h00, 8'h00);
        check8("output state bit", 8'he0, rd);
        apb(1'b1, 8'h20, 8'h00);
        check8("irq masked", 8'h00, {7'h0, irq});
        apb(1'b0, 8'h1c, 8'h00);
        check8("status sticky", 8'h01, rd);
        apb(1'b1, 8'h1c, 8'h01);
        apb(1'b0, 8'h1c, 8'h00);
        check8("status cleared", 8'h00, rd);
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h18, 8'h10);
        apb(1'b1, 8'h14, 8'h00);
        // Step 0x1000 gives a 256-tick overflow period, above every width
        for (int p = 0; p < 8; p++) begin
            apb(1'b1, 8'h00, 8'h00);
            apb(1'b1, 8'h04, {3'(p), 5'h01});
            apb(1'b1, 8'h00, 8'h81);
            measure(w);
            check8("pulse width", 8'(1 << p), 8'(w));
        end
        apb(1'b1, 8'h00, 8'h80);
        measure(w);
        check8("fixed duty run", 8'h01, {7'h0, w == 256});
        final_report();
    end
endmodule : tb_nco_top
